// *** logic/sah_ctrl.sv ***
// Successive-approximation control and 8-bit host interface
`default_nettype none
module sah_ctrl (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // Host strobes, active low, asynchronous
  input  wire logic       i_cs_n,
  input  wire logic       i_wr_n,
  input  wire logic       i_rd_n,
  // Analog front end
  input  wire logic       i_cmp_above,
  input  wire logic       i_vin_neg_ge_pos,
  output logic [9:0]      o_trial_code,
  // Data bus, one output enable shared by all lines
  output logic [7:0]      o_bus_data,
  output logic            o_bus_oe,
  // Status
  output logic            o_conversion_done_n,
  output logic            o_result_transfer_strobe
);
  // Two-flop synchronisers for every pin input except clock and reset
  localparam logic [4:0] SYNC_IDLE = 5'h07;  // Strobes high, analog flags low
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= {i_vin_neg_ge_pos, i_cmp_above, i_rd_n, i_wr_n, i_cs_n};
      sync2_r <= sync1_r;
    end
  end

  logic cs_s, wr_s, rd_s, cmp_s, neg_s;
  assign cs_s  = ~sync2_r[0];
  assign wr_s  = ~sync2_r[1];
  assign rd_s  = ~sync2_r[2];
  assign cmp_s = sync2_r[3];
  assign neg_s = sync2_r[4];

  logic start_set, read_on;
  assign start_set = cs_s & wr_s;
  assign read_on   = cs_s & rd_s;

  // Conversion state
  sah_pkg::sah_state_t state_r, state_nxt;
  logic [9:0] sar_r, sar_nxt;
  logic [9:0] token_r, token_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic       token_input_flop_r, token_input_flop_nxt;
  logic [9:0] result_r, result_nxt;
  logic       start_clear_gate;

  // Clearing pulse only lands once the set condition is gone
  // start latch release
  assign start_clear_gate = token_input_flop_r & ~start_set;

  // Sequencer next state
  always_comb begin
    state_nxt            = state_r;
    sar_nxt              = sar_r;
    token_nxt            = token_r;
    phase_nxt            = phase_r;
    token_input_flop_nxt = token_input_flop_r;
    result_nxt           = result_r;
    if (start_set) begin
      state_nxt            = sah_pkg::SAH_HOLD;
      sar_nxt              = sah_pkg::CODE_ZERO;
      token_nxt            = sah_pkg::CODE_ZERO;
      phase_nxt            = sah_pkg::PHASE_FIRST;
      token_input_flop_nxt = 1'b1;
    end else begin
      case (state_r)
        sah_pkg::SAH_IDLE: begin
          token_input_flop_nxt = 1'b0;
        end
        sah_pkg::SAH_HOLD: begin
          if (start_clear_gate) begin
            state_nxt            = sah_pkg::SAH_CONV;
            token_nxt            = sah_pkg::TOKEN_MSB;
            phase_nxt            = sah_pkg::PHASE_FIRST;
            token_input_flop_nxt = 1'b0;
          end
        end
        sah_pkg::SAH_CONV: begin
          phase_nxt = phase_r + 3'h1;
          if (phase_r == sah_pkg::PHASE_COMPARE) begin
            // keep bit when input above trial
            if (cmp_s) begin
              sar_nxt = sar_r | token_r;
            end
            token_nxt = token_r >> 1;
            if (token_r[0]) begin
              state_nxt = sah_pkg::SAH_RESULT_TRANSFER_STROBE;
            end
          end
        end
        sah_pkg::SAH_RESULT_TRANSFER_STROBE: begin
          result_nxt = neg_s ? sah_pkg::CODE_ZERO : sar_r;
          state_nxt  = sah_pkg::SAH_IDLE;
        end
        default: begin
          state_nxt = sah_pkg::SAH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r            <= sah_pkg::SAH_IDLE;
      sar_r              <= sah_pkg::CODE_ZERO;
      token_r            <= sah_pkg::CODE_ZERO;
      phase_r            <= sah_pkg::PHASE_FIRST;
      token_input_flop_r <= 1'b0;
      result_r           <= sah_pkg::CODE_ZERO;
    end else begin
      state_r            <= state_nxt;
      sar_r              <= sar_nxt;
      token_r            <= token_nxt;
      phase_r            <= phase_nxt;
      token_input_flop_r <= token_input_flop_nxt;
      result_r           <= result_nxt;
    end
  end

  // Trial code presented to the ladder
  assign o_trial_code             = sar_r | token_r;
  assign o_result_transfer_strobe = (state_r == sah_pkg::SAH_RESULT_TRANSFER_STROBE);

  // One-shot fires on the falling edge of the transfer strobe
  logic result_transfer_strobe_q_r, shot_active, shot_fire;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      result_transfer_strobe_q_r <= 1'b0;
    end else begin
      result_transfer_strobe_q_r <= o_result_transfer_strobe;
    end
  end
  assign shot_fire = result_transfer_strobe_q_r & ~o_result_transfer_strobe;

  sah_oneshot u_oneshot (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_fire    (shot_fire),
    .o_active  (shot_active)
  );

  // Done flag and byte selector
  logic done_r, done_nxt;
  logic sel_lo_r, sel_lo_nxt;
  logic read_q_r, read_q_nxt;
  always_comb begin
    done_nxt   = done_r;
    sel_lo_nxt = sel_lo_r;
    read_q_nxt = read_on;
    // Set wins over any clear in the same cycle
    // read clears flag
    if (read_on || start_set) begin
      done_nxt = 1'b0;
    end
    if (shot_active) begin
      done_nxt = 1'b1;
    end
    if (read_q_r && !read_on) begin
      sel_lo_nxt = ~sel_lo_r;
    end
    if (o_result_transfer_strobe) begin
      sel_lo_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      done_r   <= 1'b0;
      sel_lo_r <= 1'b0;
      read_q_r <= 1'b0;
    end else begin
      done_r   <= done_nxt;
      sel_lo_r <= sel_lo_nxt;
      read_q_r <= read_q_nxt;
    end
  end

  assign o_conversion_done_n = ~(done_r | shot_active);

  // Registered byte, chosen ahead so it is stable when the bus opens
  logic [7:0] byte_r, byte_nxt;
  always_comb begin
    if (sel_lo_r) begin
      byte_nxt = {result_r[sah_pkg::LO_MSB:0], sah_pkg::LO_PAD_ZERO};
    end else begin
      byte_nxt = result_r[sah_pkg::HI_MSB:sah_pkg::HI_LSB];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      byte_r <= sah_pkg::BYTE_ZERO;
    end else begin
      byte_r <= byte_nxt;
    end
  end

  assign o_bus_data = byte_r;
  assign o_bus_oe   = read_on;
endmodule
`default_nettype wire

// *** logic/sah_pkg.sv ***
// Shared constants for the converter control and host interface
`default_nettype none
package sah_pkg;
  // Resolution and sequencing
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned PHASE_W       = 3;
  localparam logic [2:0]  PHASE_FIRST   = 3'h0;
  localparam logic [2:0]  PHASE_COMPARE = 3'h7;  // Eight clocks per comparison
  localparam logic [9:0]  TOKEN_MSB     = 10'h200;
  localparam logic [9:0]  CODE_ZERO     = 10'h000;
  // Bus byte layout
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam int unsigned HI_MSB        = 9;
  localparam int unsigned HI_LSB        = 2;
  localparam int unsigned LO_MSB        = 1;
  localparam int unsigned LO_PAD        = 6;
  localparam logic [5:0]  LO_PAD_ZERO   = 6'h00;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ONE_SHOT_NS   = 400;
  localparam int unsigned ONE_SHOT_CYC  = ONE_SHOT_NS / CLK_PERIOD_NS;
  localparam int unsigned SHOT_W        = 5;
  // Conversion control states, Gray along idle-hold-convert-transfer
  typedef enum logic [1:0] {
    SAH_IDLE = 2'h0,
    SAH_HOLD = 2'h1,
    SAH_CONV = 2'h3,
    SAH_RESULT_TRANSFER_STROBE = 2'h2
  } sah_state_t;
endpackage
`default_nettype wire

// *** logic/sah_oneshot.sv ***
// One-shot that stretches the transfer strobe into the done set pulse
`default_nettype none
module sah_oneshot (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  // Trigger and pulse
  input  wire logic i_fire,
  output logic      o_active
);
  localparam logic [4:0] SHOT_LOAD = 5'(sah_pkg::ONE_SHOT_CYC);
  localparam logic [4:0] SHOT_NONE = 5'h00;
  localparam logic [4:0] SHOT_STEP = 5'h01;

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;

  // Retrigger reloads; otherwise count down to idle
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_fire) begin
      cnt_nxt = SHOT_LOAD;
    end else if (cnt_r != SHOT_NONE) begin
      cnt_nxt = cnt_r - SHOT_STEP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= SHOT_NONE;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Pulse width is exactly the load count
  assign o_active = (cnt_r != SHOT_NONE);
endmodule
`default_nettype wire

// *** test/sah_ctrl_sva.sv ***
// Port checker for the converter control block
`default_nettype none
module sah_ctrl_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_cs_n,
  input wire logic       i_wr_n,
  input wire logic       i_rd_n,
  input wire logic [9:0] o_trial_code,
  input wire logic       o_bus_oe,
  input wire logic       o_conversion_done_n,
  input wire logic       o_result_transfer_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       held_w;
  logic [7:0] rel_r;
  logic [7:0] rel_nxt;
  // Cycles since start pins released, saturating so it never wraps
  assign held_w = !i_cs_n && !i_wr_n;
  always_comb rel_nxt = held_w ? 8'h00 : rel_r + {7'h00, rel_r != 8'hFF};
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) rel_r <= 8'hFF;
    else rel_r <= rel_nxt;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  property p_len; o_result_transfer_strobe |-> rel_r inside {[8'h50:8'h5A]}; endproperty
  a_len: assert property (p_len) else $error("latch outside window");
  property p_one; o_result_transfer_strobe |=> !o_result_transfer_strobe; endproperty
  a_one: assert property (p_one) else $error("strobe too long");
  property p_set; o_result_transfer_strobe |-> ##[1:2] !o_conversion_done_n; endproperty
  a_set: assert property (p_set) else $error("done not set");
  property p_cause; $fell(o_conversion_done_n) |-> $past(o_result_transfer_strobe) ||
    $past(o_result_transfer_strobe, 2); endproperty
  a_cause: assert property (p_cause) else $error("done without latch");
  property p_shot; $fell(o_conversion_done_n) |-> !o_conversion_done_n [*8]; endproperty
  a_shot: assert property (p_shot) else $error("done pulse short");
  property p_oe; o_bus_oe |-> !$past(i_cs_n, 2) && !$past(i_rd_n, 2); endproperty
  a_oe: assert property (p_oe) else $error("bus driven unasked");
  property p_hiz; $rose(i_rd_n) |-> ##[1:3] !o_bus_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("bus not released");
  property p_hold; $past(held_w, 2) && $past(held_w, 3) |-> o_trial_code == 10'h000; endproperty
  a_hold: assert property (p_hold) else $error("logic runs during start");
endmodule
bind sah_ctrl sah_ctrl_sva u_sva (.i_ref_clk, .i_rstn, .i_cs_n, .i_wr_n, .i_rd_n, .o_trial_code,
  .o_bus_oe, .o_conversion_done_n, .o_result_transfer_strobe);
`default_nettype wire

// *** test/sah_afe_model.sv ***
// Ideal comparator standing in for the analog front end
`default_nettype none
module sah_afe_model (
  // Ladder trial and input level as a code
  input  wire logic [9:0] i_trial_code,
  input  wire logic [9:0] i_level,
  // Verdict
  output logic            o_cmp_above
);
  timeunit 1ns;
  timeprecision 1ps;
  // bit kept while input reaches trial
  assign o_cmp_above = i_level >= i_trial_code;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the converter control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_ref_clk, i_rstn, i_cs_n, i_wr_n, i_rd_n, cmp_above, vin_neg, bus_oe, done_n, result_transfer_strobe;
  logic [9:0] trial, level;
  logic [7:0] bus_data;
  int         n_errors = 0;
  int         tests_run = 0;
  sah_ctrl uut (.i_ref_clk, .i_rstn, .i_cs_n, .i_wr_n, .i_rd_n, .i_cmp_above(cmp_above),
    .i_vin_neg_ge_pos(vin_neg), .o_trial_code(trial), .o_bus_data(bus_data), .o_bus_oe(bus_oe),
    .o_conversion_done_n(done_n), .o_result_transfer_strobe(result_transfer_strobe));
  sah_afe_model u_afe (.i_trial_code(trial), .i_level(level), .o_cmp_above(cmp_above));
  // Conversion clock
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail_out();
    n_errors++;
    end_of_test();
  endtask
  // Start held for some cycles, then time the latch
  task automatic start_conv(input int hold);
    int n;
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_wr_n = 1'b0;
    repeat (hold) @(negedge i_ref_clk);
    if (hold > 8) begin
      chk({9'h000, done_n}, 10'h001);
      chk(trial, 10'h000);
    end
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    for (n = 1; n < 200 && result_transfer_strobe !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 200) fail_out();
    chk(10'(n inside {[80:90]}), 10'h001);
    repeat (2) @(negedge i_ref_clk);
    chk({9'h000, done_n}, 10'h000);
  endtask
  // One read cycle, request held until the bus answers
  task automatic read_byte(input logic [7:0] exp);
    int n;
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_rd_n = 1'b0;
    for (n = 0; n < 20 && bus_oe !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 20) fail_out();
    chk({2'h0, bus_data}, {2'h0, exp});
    i_cs_n = 1'b1;
    i_rd_n = 1'b1;
    for (n = 0; n < 20 && bus_oe !== 1'b0; n++) @(negedge i_ref_clk);
    if (n == 20) fail_out();
    repeat (2) @(negedge i_ref_clk);
  endtask
  // Conversion at one level, then three reads
  task automatic run_case(input logic [9:0] lvl, input logic neg, input int hold);
    logic [9:0] exp;
    level = lvl;
    vin_neg = neg;
    exp = neg ? 10'h000 : lvl;
    start_conv(hold);
    repeat (22) @(negedge i_ref_clk);
    chk({9'h000, done_n}, 10'h000);
    read_byte(exp[9:2]);
    chk({9'h000, done_n}, 10'h001);
    read_byte({exp[1:0], 6'h00});
    read_byte(exp[9:2]);
  endtask
  // Read held low through the whole conversion, done still pulses
  task automatic rd_held();
    int n;
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_rd_n = 1'b0;
    i_wr_n = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    i_wr_n = 1'b1;
    for (n = 1; n < 200 && result_transfer_strobe !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 200) fail_out();
    repeat (2) @(negedge i_ref_clk);
    chk({9'h000, done_n}, 10'h000);
    repeat (14) @(negedge i_ref_clk);
    chk({9'h000, done_n}, 10'h000);
    repeat (10) @(negedge i_ref_clk);
    chk({9'h000, done_n}, 10'h001);
    i_cs_n = 1'b1;
    i_rd_n = 1'b1;
    repeat (3) @(negedge i_ref_clk);
  endtask
  // Reset in mid-conversion returns outputs to idle
  task automatic mid_reset();
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_wr_n = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    repeat (40) @(negedge i_ref_clk);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk(trial, 10'h000);
    chk({8'h00, result_transfer_strobe, done_n}, 10'h001);
    chk({1'b0, bus_oe, bus_data}, 10'h000);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_ref_clk);
  endtask
  // Free-running: chip select low, write follows done after a forced start
  task automatic free_run();
    int n;
    int seen;
    seen = 0;
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_wr_n = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    for (n = 0; n < 250; n++) begin
      i_wr_n = done_n;
      if (result_transfer_strobe === 1'b1) seen++;
      @(negedge i_ref_clk);
    end
    chk(10'(seen), 10'h002);
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    repeat (3) @(negedge i_ref_clk);
  endtask
  // Reset, then scenarios; the unread start tests the done clear
  initial begin
    i_rstn = 1'b0;
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    i_rd_n = 1'b1;
    vin_neg = 1'b0;
    level = 10'h000;
    repeat (3) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    run_case(10'h2A5, 1'b0, 3);
    start_conv(3);
    run_case(10'h3FF, 1'b0, 150);
    rd_held();
    mid_reset();
    run_case(10'h3FF, 1'b1, 3);
    run_case(10'h001, 1'b0, 3);
    free_run();
    end_of_test();
  end
endmodule
`default_nettype wire
